/* File: hw/llpu_regs.svh */
`ifndef LLPU_REGS_SVH
`define LLPU_REGS_SVH

// register port offsets
`define LLPU_OFF_LINK_LO 8'h00
`define LLPU_OFF_LINK_HI 8'h04
`define LLPU_OFF_CONFIG 8'h08
`define LLPU_OFF_STATUS 8'h0C

// configuration fields
`define LLPU_CFG_NO_PAIR_BIT 0
`define LLPU_CFG_REL_LSB 4
`define LLPU_CFG_REL_MSB 7
`define LLPU_CFG_NO_PAIR_RST 1'b0

// status fields
`define LLPU_STAT_BUSY_BIT 0
`define LLPU_STAT_EXC_LSB 4
`define LLPU_STAT_EXC_MSB 6

// first release with paired forms
`define LLPU_PAIR_MIN_REL 4'h6

// step to the high half of a pair
`define LLPU_STEP_DOUBLE 64'h0000000000000008
`define LLPU_STEP_WORD 64'h0000000000000004

`endif

/* File: hw/llpu_pkg.sv */
package llpu_pkg;

	typedef enum logic [1:0] {
		LLPU_OP_USER_WORD,
		LLPU_OP_PAIR_DOUBLE,
		LLPU_OP_PAIR_WORD
	} llpu_op_t;

	typedef enum logic [2:0] {
		LLPU_EXC_NONE,
		LLPU_EXC_TLB_REFILL,
		LLPU_EXC_TLB_INVALID,
		LLPU_EXC_ADDR_ERROR,
		LLPU_EXC_RESERVED,
		LLPU_EXC_WATCH,
		LLPU_EXC_CP_UNUSABLE
	} llpu_exc_t;

	typedef enum logic [1:0] {
		LLPU_ST_IDLE,
		LLPU_ST_XLATE,
		LLPU_ST_MEM_LO,
		LLPU_ST_MEM_HI
	} llpu_state_t;

	typedef struct packed {
		llpu_op_t op;
		logic [63:0] base;
		logic [8:0] offset;
		logic cpu_big_byte_order;
		logic byte_order_swap;
		logic user_word_en;
		logic cp_usable;
	} llpu_req_t;

	typedef struct packed {
		logic valid;
		logic [63:0] paddr;
		logic refill;
		logic invalid;
		logic watch;
	} llpu_xl_resp_t;

	typedef struct packed {
		llpu_op_t op;
		logic [63:0] low_data;
		logic [63:0] high_data;
		logic write_high;
		llpu_exc_t exc;
	} llpu_res_t;

endpackage

/* File: hw/llpu_unit.sv */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "llpu_regs.svh"

// How it works
// - user word: lane pick, sign extend, set flag
// - user word raises its listed exceptions
// - pair double: 128 bits split low/high
// - pair double: two locked double accesses
// - pair forms use base as address
// - pair double replaces active sequence
// - store conditional closes the sequence
// - pair double links quad aligned address
// - flag is bit zero of link address
// - loads never disturb other processors
// - sequence may be abandoned freely
// - cacheless build may drop link address
// - misaligned pair support not required
// - pair forms need release six, field zero
// - pair forms raise their listed exceptions
// - pair word: sign extend both words
// - pair word: two locked word accesses
// - pair word replaces, links double address
// - user word misaligned gives address error
module llpu_unit
	import llpu_pkg::*;
#(
	parameter logic HAS_LINK_ADDR = 1'b1,
	parameter logic [3:0] RELEASE = 4'h6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// request from the pipeline
	input wire logic req_valid,
	input wire llpu_req_t req,
	output logic req_ready,
	// address translation
	output logic xl_req,
	output logic [63:0] xl_vaddr,
	input wire llpu_xl_resp_t xl_resp,
	// memory
	output logic mem_req,
	output logic [63:0] mem_addr,
	output logic mem_lock,
	input wire logic mem_rvalid,
	input wire logic [63:0] mem_rdata,
	// result to register writeback
	output logic res_valid,
	output llpu_res_t res,
	// link state
	input wire logic sc_close,
	input wire logic link_break,
	output logic link_valid_flag,
	output logic [63:0] link_address_register,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	typedef struct packed {
		llpu_state_t st;
		logic ready;
		logic xl_req;
		logic [63:0] vaddr;
		logic [63:0] paddr;
		logic big;
		logic swap;
		logic mem_req;
		logic [63:0] mem_addr;
		logic mem_lock;
		logic res_valid;
		llpu_res_t res;
		logic [63:0] link;
		logic flag;
		logic no_pair;
		logic [3:0] release_lvl;
		llpu_exc_t last_exc;
		logic [31:0] rdata;
	} llpu_state_s_t;

	llpu_state_s_t s;
	llpu_state_s_t next_s;

	logic take;
	logic [63:0] va;
	logic [63:0] step;
	logic [2:0] lane;
	logic [31:0] word;
	logic [63:0] link_val;
	llpu_exc_t pre_exc;
	logic is_pair;

	assign take = req_valid && s.ready;
	assign is_pair = (req.op != LLPU_OP_USER_WORD);
	assign step = (s.res.op == LLPU_OP_PAIR_DOUBLE) ?
		`LLPU_STEP_DOUBLE : `LLPU_STEP_WORD;
	// big-endian cpu flips the word lane
	assign lane = s.vaddr[2:0] ^ {s.big, 2'b00};
	assign word = lane[2] ? mem_rdata[63:32] : mem_rdata[31:0];
	// cacheless build keeps only the flag
	assign link_val = HAS_LINK_ADDR ?
		{s.paddr[63:1], 1'b1} : 64'h0000000000000001;

	// address forms
	always_comb begin
		if (is_pair) begin
			va = req.base;
		end else begin
			va = req.base + {{55{req.offset[8]}}, req.offset};
		end
	end

	// checks made before translation
	always_comb begin
		pre_exc = LLPU_EXC_NONE;
		case (req.op)
			LLPU_OP_USER_WORD: begin
				if (!req.user_word_en) begin
					pre_exc = LLPU_EXC_RESERVED;
				end else if (!req.cp_usable) begin
					pre_exc = LLPU_EXC_CP_UNUSABLE;
				end else if (va[1:0] != 2'h0) begin
					pre_exc = LLPU_EXC_ADDR_ERROR;
				end
			end
			LLPU_OP_PAIR_DOUBLE: begin
				if (s.release_lvl < `LLPU_PAIR_MIN_REL || s.no_pair) begin
					pre_exc = LLPU_EXC_RESERVED;
				end else if (va[3:0] != 4'h0) begin
					pre_exc = LLPU_EXC_ADDR_ERROR;
				end
			end
			LLPU_OP_PAIR_WORD: begin
				if (s.release_lvl < `LLPU_PAIR_MIN_REL || s.no_pair) begin
					pre_exc = LLPU_EXC_RESERVED;
				end else if (va[2:0] != 3'h0) begin
					pre_exc = LLPU_EXC_ADDR_ERROR;
				end
			end
			default: begin
				pre_exc = LLPU_EXC_RESERVED;
			end
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.xl_req = 1'b0;
		next_s.mem_req = 1'b0;
		next_s.res_valid = 1'b0;
		next_s.rdata = 32'h00000000;
		// closing or losing the link drops the flag
		if (sc_close || link_break) begin
			next_s.flag = 1'b0;
			next_s.link[0] = 1'b0;
		end
		case (s.st)
			LLPU_ST_IDLE: begin
				if (take) begin
					next_s.ready = 1'b0;
					next_s.vaddr = va;
					next_s.big = req.cpu_big_byte_order;
					// request may change once taken, keep the swap
					next_s.swap = req.byte_order_swap;
					next_s.res.op = req.op;
					next_s.res.low_data = 64'h0000000000000000;
					next_s.res.high_data = 64'h0000000000000000;
					next_s.res.write_high = is_pair;
					next_s.res.exc = pre_exc;
					if (pre_exc != LLPU_EXC_NONE) begin
						// link left as it was
						next_s.res_valid = 1'b1;
						next_s.ready = 1'b1;
						next_s.last_exc = pre_exc;
					end else begin
						next_s.xl_req = 1'b1;
						next_s.st = LLPU_ST_XLATE;
					end
				end
			end
			LLPU_ST_XLATE: begin
				if (xl_resp.valid) begin
					next_s.paddr = xl_resp.paddr;
					if (xl_resp.refill) begin
						next_s.res.exc = LLPU_EXC_TLB_REFILL;
					end else if (xl_resp.invalid) begin
						next_s.res.exc = LLPU_EXC_TLB_INVALID;
					end else if (xl_resp.watch) begin
						next_s.res.exc = LLPU_EXC_WATCH;
					end
					if (xl_resp.refill || xl_resp.invalid || xl_resp.watch) begin
						next_s.res_valid = 1'b1;
						next_s.ready = 1'b1;
						next_s.last_exc = next_s.res.exc;
						next_s.st = LLPU_ST_IDLE;
					end else begin
						next_s.mem_req = 1'b1;
						// pair accesses hold the lock throughout
						next_s.mem_lock = s.res.write_high;
						if (s.res.write_high) begin
							next_s.mem_addr = xl_resp.paddr;
						end else begin
							next_s.mem_addr = {xl_resp.paddr[63:3],
								xl_resp.paddr[2:0] ^ {s.swap, 2'b00}};
						end
						next_s.st = LLPU_ST_MEM_LO;
					end
				end
			end
			LLPU_ST_MEM_LO: begin
				if (mem_rvalid) begin
					case (s.res.op)
						LLPU_OP_PAIR_DOUBLE: begin
							next_s.res.low_data = mem_rdata;
						end
						LLPU_OP_PAIR_WORD: begin
							next_s.res.low_data = {{32{mem_rdata[31]}},
								mem_rdata[31:0]};
						end
						default: begin
							next_s.res.low_data = {{32{word[31]}}, word};
						end
					endcase
					if (s.res.write_high) begin
						next_s.mem_req = 1'b1;
						next_s.mem_addr = s.paddr + step;
						next_s.st = LLPU_ST_MEM_HI;
					end else begin
						next_s.res_valid = 1'b1;
						next_s.ready = 1'b1;
						next_s.last_exc = LLPU_EXC_NONE;
						// a new load overrides older link, set beats clear
						next_s.flag = 1'b1;
						next_s.link = link_val;
						next_s.st = LLPU_ST_IDLE;
					end
				end
			end
			LLPU_ST_MEM_HI: begin
				if (mem_rvalid) begin
					if (s.res.op == LLPU_OP_PAIR_DOUBLE) begin
						next_s.res.high_data = mem_rdata;
					end else begin
						next_s.res.high_data = {{32{mem_rdata[63]}},
							mem_rdata[63:32]};
					end
					next_s.mem_lock = 1'b0;
					next_s.res_valid = 1'b1;
					next_s.ready = 1'b1;
					next_s.last_exc = LLPU_EXC_NONE;
					// only the local link is touched, nothing goes out
					next_s.flag = 1'b1;
					next_s.link = link_val;
					next_s.st = LLPU_ST_IDLE;
				end
			end
			default: begin
				next_s.st = LLPU_ST_IDLE;
				next_s.ready = 1'b1;
				next_s.mem_lock = 1'b0;
			end
		endcase
		// register writes
		if (reg_wr && reg_addr == `LLPU_OFF_CONFIG) begin
			next_s.no_pair = reg_wdata[`LLPU_CFG_NO_PAIR_BIT];
			next_s.release_lvl = reg_wdata[`LLPU_CFG_REL_MSB:`LLPU_CFG_REL_LSB];
		end
		// register reads, data in the following cycle
		if (reg_rd) begin
			case (reg_addr)
				`LLPU_OFF_LINK_LO: begin
					next_s.rdata = s.link[31:0];
				end
				`LLPU_OFF_LINK_HI: begin
					next_s.rdata = s.link[63:32];
				end
				`LLPU_OFF_CONFIG: begin
					next_s.rdata[`LLPU_CFG_NO_PAIR_BIT] = s.no_pair;
					next_s.rdata[`LLPU_CFG_REL_MSB:`LLPU_CFG_REL_LSB] =
						s.release_lvl;
				end
				`LLPU_OFF_STATUS: begin
					next_s.rdata[`LLPU_STAT_BUSY_BIT] = !s.ready;
					next_s.rdata[`LLPU_STAT_EXC_MSB:`LLPU_STAT_EXC_LSB] =
						s.last_exc;
				end
				default: begin
					next_s.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
			s.st <= LLPU_ST_IDLE;
			s.ready <= 1'b1;
			s.no_pair <= `LLPU_CFG_NO_PAIR_RST;
			s.release_lvl <= RELEASE;
			s.last_exc <= LLPU_EXC_NONE;
		end else begin
			s <= next_s;
		end
	end

	assign req_ready = s.ready;
	assign xl_req = s.xl_req;
	assign xl_vaddr = s.vaddr;
	assign mem_req = s.mem_req;
	assign mem_addr = s.mem_addr;
	assign mem_lock = s.mem_lock;
	assign res_valid = s.res_valid;
	assign res = s.res;
	assign link_valid_flag = s.flag;
	assign link_address_register = s.link;
	assign reg_rdata = s.rdata;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_USER_SEXT: assert property (
		res_valid && res.op == LLPU_OP_USER_WORD && res.exc == LLPU_EXC_NONE
		|-> res.low_data[63:32] == {32{res.low_data[31]}} && link_valid_flag)
		else $error("user word result not sign extended or flag clear");

	AST_USER_ALIGN: assert property (
		take && req.op == LLPU_OP_USER_WORD && req.user_word_en &&
		req.cp_usable && va[1:0] != 2'h0
		|=> res_valid && res.exc == LLPU_EXC_ADDR_ERROR)
		else $error("misaligned user word without address error");

	AST_PAIR_RESERVED: assert property (
		take && is_pair && (s.no_pair || s.release_lvl < 4'h6)
		|=> res_valid && res.exc == LLPU_EXC_RESERVED && !xl_req)
		else $error("pair form not reserved when unavailable");

	AST_FLAG_IS_BIT0: assert property (
		link_valid_flag == link_address_register[0])
		else $error("flag differs from link address bit zero");

	AST_DOUBLE_LINK: assert property (
		res_valid && res.op == LLPU_OP_PAIR_DOUBLE &&
		res.exc == LLPU_EXC_NONE
		|-> link_address_register[3:0] == 4'h1)
		else $error("pair double link address not quad aligned");

	AST_WORD_LINK: assert property (
		res_valid && res.op == LLPU_OP_PAIR_WORD && res.exc == LLPU_EXC_NONE
		|-> link_address_register[2:0] == 3'h1 &&
		res.high_data[63:32] == {32{res.high_data[31]}})
		else $error("pair word link or high sign wrong");

	AST_LOCK_HELD: assert property (
		s.st == LLPU_ST_MEM_LO && mem_rvalid && mem_lock
		|=> mem_req && mem_lock && mem_addr == $past(s.paddr) + step)
		else $error("second pair access not locked");

	AST_EXC_KEEPS_LINK: assert property (
		res_valid && res.exc != LLPU_EXC_NONE &&
		!$past(sc_close) && !$past(link_break)
		|-> $stable(link_address_register))
		else $error("faulting load changed the link");

	AST_BASE_ADDR: assert property (
		take && is_pair && pre_exc == LLPU_EXC_NONE
		|=> xl_req && xl_vaddr == $past(req.base))
		else $error("pair address differs from base");

	AST_CLOSE_CLEARS: assert property (
		(sc_close || link_break) && s.st == LLPU_ST_IDLE
		|=> !link_valid_flag)
		else $error("flag survives close");

endmodule // llpu_unit

/* File: verification/llpu_mem_model.sv */
`timescale 1ns/100ps
module llpu_mem_model
	import llpu_pkg::*;
#(
	parameter logic [63:0] PA_OFFSET = 64'h0000010000000000
) (
	// clock
	input wire logic clk,
	// translation
	input wire logic xl_req,
	input wire logic [63:0] xl_vaddr,
	output llpu_xl_resp_t xl_resp,
	// memory
	input wire logic mem_req,
	input wire logic [63:0] mem_addr,
	output logic mem_rvalid,
	output logic [63:0] mem_rdata,
	// behaviour control
	input wire logic slow,
	input wire logic [2:0] fault
);
	logic [3:0] xl_cnt;
	logic [3:0] mem_cnt;
	logic [63:0] addr_q;

	function automatic logic [63:0] pattern(input logic [63:0] a);
		return {a[31:0] ^ 32'h9E3779B9, ~a[31:0]};
	endfunction

	initial begin
		xl_resp = '0;
		mem_rvalid = 1'b0;
		mem_rdata = 64'h0;
		xl_cnt = 4'h0;
		mem_cnt = 4'h0;
		addr_q = 64'h0;
	end

	// idle lines toggle so stale data never looks valid
	always @(posedge clk) begin
		if (xl_req) begin
			xl_cnt <= slow ? 4'h3 : 4'h1;
		end else if (xl_cnt != 4'h0) begin
			xl_cnt <= xl_cnt - 4'h1;
		end
		if (!xl_req && xl_cnt == 4'h1) begin
			xl_resp <= {1'b1, xl_vaddr + PA_OFFSET, fault};
		end else begin
			xl_resp.valid <= 1'b0;
			xl_resp.paddr <= ~xl_resp.paddr;
		end
		if (mem_req) begin
			mem_cnt <= slow ? 4'h4 : 4'h1;
			addr_q <= mem_addr;
		end else if (mem_cnt != 4'h0) begin
			mem_cnt <= mem_cnt - 4'h1;
		end
		// every location is synchronizable here
		if (!mem_req && mem_cnt == 4'h1) begin
			mem_rvalid <= 1'b1;
			mem_rdata <= pattern(addr_q);
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // llpu_mem_model

/* File: verification/llpu_unit_test.sv */
`timescale 1ns/100ps
`include "llpu_regs.svh"
module llpu_unit_test
	import llpu_pkg::*;
;
	localparam logic [63:0] PA_OFFSET = 64'h0000010000000000;
	logic clk, rst_b, req_valid, req_ready, xl_req, mem_req, mem_lock;
	logic mem_rvalid, res_valid, sc_close, link_break, link_valid_flag;
	logic reg_wr, reg_rd, slow;
	logic [2:0] fault;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [63:0] xl_vaddr, mem_addr, mem_rdata, link_address_register;
	logic [63:0] base, exp_link;
	llpu_req_t req;
	llpu_xl_resp_t xl_resp;
	llpu_res_t res;
	llpu_op_t op;
	logic [64:0] mq[$];
	integer seed = 32'h0a430052;
	int miscompares = 0;
	int compares = 0;

	llpu_unit #(.HAS_LINK_ADDR(1'b1), .RELEASE(4'h6)) u_llpu_unit (
		.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .xl_req(xl_req), .xl_vaddr(xl_vaddr),
		.xl_resp(xl_resp), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_lock(mem_lock), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.res_valid(res_valid), .res(res), .sc_close(sc_close),
		.link_break(link_break), .link_valid_flag(link_valid_flag),
		.link_address_register(link_address_register), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	llpu_mem_model #(.PA_OFFSET(PA_OFFSET)) u_llpu_mem_model (
		.clk(clk), .xl_req(xl_req), .xl_vaddr(xl_vaddr), .xl_resp(xl_resp),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .slow(slow), .fault(fault));

	always #4 clk = ~clk;
	always @(negedge clk) if (mem_req === 1'b1) mq.push_back({mem_lock, mem_addr});

	function automatic logic [63:0] pat(input logic [63:0] a);
		return {a[31:0] ^ 32'h9E3779B9, ~a[31:0]};
	endfunction
	function automatic logic [63:0] sx(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction

	task automatic check(input string n, input logic [64:0] e, g);
		compares++;
		if (e !== g) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic pulse_clear(input logic brk);
		@(posedge clk);
		if (brk) link_break <= 1'b1;
		else sc_close <= 1'b1;
		@(posedge clk);
		link_break <= 1'b0;
		sc_close <= 1'b0;
		@(negedge clk);
		check("flag_clear", 0, link_valid_flag);
		check("flag_bit0", 0, link_address_register[0]);
	endtask

	// flags: big order, swap, user word enabled, coprocessor usable
	task automatic run(input llpu_op_t o, input logic [63:0] b,
		input logic [8:0] off, input logic [3:0] f, input llpu_exc_t ex);
		logic [63:0] va, pa, a0, st, lk, d0, d1;
		int n;
		va = (o == LLPU_OP_USER_WORD) ? b + {{55{off[8]}}, off} : b;
		pa = va + PA_OFFSET;
		st = (o == LLPU_OP_PAIR_DOUBLE) ? 64'h8 : 64'h4;
		lk = link_address_register;
		@(posedge clk);
		mq.delete();
		// no register numbers travel here, destinations never collide
		req <= '{o, b, off, f[3], f[2], f[1], f[0]};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (res_valid !== 1'b1 && n < 200);
		check("res_valid", 1, res_valid);
		check("ready", 1, req_ready);
		check("lock_free", 0, mem_lock);
		check("op", o, res.op);
		check("exc", ex, res.exc);
		if (ex != LLPU_EXC_NONE) begin
			check("link_kept", lk, link_address_register);
		end else if (o == LLPU_OP_USER_WORD) begin
			a0 = {pa[63:3], pa[2:0] ^ {f[2], 2'b00}};
			d0 = pat(a0);
			check("acc_addr", {1'b0, a0}, mq[0]);
			check("write_high", 0, res.write_high);
			check("low", sx((va[2] ^ f[3]) ? d0[63:32] : d0[31:0]),
				res.low_data);
			check("flag", 1, link_valid_flag);
		end else begin
			d0 = pat(pa);
			d1 = pat(pa + st);
			check("accesses", 2, mq.size());
			for (int i = 0; i < 2; i++) begin
				check("acc", {1'b1, pa + i * st}, mq[i]);
			end
			check("write_high", 1, res.write_high);
			if (o == LLPU_OP_PAIR_DOUBLE) begin
				check("low", d0, res.low_data);
				check("high", d1, res.high_data);
			end else begin
				check("low", sx(d0[31:0]), res.low_data);
				check("high", sx(d1[63:32]), res.high_data);
			end
			exp_link = {pa[63:1], 1'b1};
			check("link", exp_link, link_address_register);
		end
	endtask

	initial begin
		clk = 0; rst_b = 0; req_valid = 0; req = '0; sc_close = 0;
		link_break = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
		slow = 0; fault = 0; exp_link = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		check("ready_rst", 1, req_ready);
		check("link_rst", 0, link_address_register);
		rd(`LLPU_OFF_CONFIG, rv);
		check("config_rst", 32'h60, rv);
		for (int i = 0; i < 40; i++) begin
			op = llpu_op_t'($unsigned($random(seed)) % 3);
			base = {$random(seed), $random(seed)} & ~64'hF;
			slow <= 1'($random(seed));
			run(op, base, 9'($random(seed)) & 9'h1FC,
				{2'($random(seed)), 2'b11}, LLPU_EXC_NONE);
		end
		run(LLPU_OP_USER_WORD, 64'h1002, 9'h0, 4'h3,
			LLPU_EXC_ADDR_ERROR);
		run(LLPU_OP_PAIR_DOUBLE, 64'h1008, 9'h0, 4'h3,
			LLPU_EXC_ADDR_ERROR);
		run(LLPU_OP_PAIR_WORD, 64'h1004, 9'h0, 4'h3,
			LLPU_EXC_ADDR_ERROR);
		run(LLPU_OP_USER_WORD, 64'h1000, 9'h0, 4'h1,
			LLPU_EXC_RESERVED);
		run(LLPU_OP_USER_WORD, 64'h1000, 9'h0, 4'h2,
			LLPU_EXC_CP_UNUSABLE);
		for (int i = 0; i < 6; i++) begin
			fault <= 3'h4 >> (i % 3);
			run(llpu_op_t'(i / 3), 64'h2000, 9'h0, 4'h3,
				llpu_exc_t'(i % 3 == 2 ? 5 : i % 3 + 1));
		end
		fault <= 3'h0;
		rd(`LLPU_OFF_STATUS, rv);
		check("status_exc", 5, rv[6:4]);
		wr(`LLPU_OFF_CONFIG, 32'h61);
		run(LLPU_OP_PAIR_DOUBLE, 64'h3000, 9'h0, 4'h3,
			LLPU_EXC_RESERVED);
		run(LLPU_OP_PAIR_WORD, 64'h3000, 9'h0, 4'h3,
			LLPU_EXC_RESERVED);
		// release below six, field clear: still reserved
		wr(`LLPU_OFF_CONFIG, 32'h50);
		rd(`LLPU_OFF_CONFIG, rv);
		check("config_rd", 32'h50, rv);
		run(LLPU_OP_PAIR_DOUBLE, 64'h3000, 9'h0, 4'h3,
			LLPU_EXC_RESERVED);
		run(LLPU_OP_PAIR_WORD, 64'h3000, 9'h0, 4'h3,
			LLPU_EXC_RESERVED);
		wr(`LLPU_OFF_CONFIG, 32'h60);
		run(LLPU_OP_PAIR_WORD, 64'hFFF8, 9'h0, 4'h3, LLPU_EXC_NONE);
		run(LLPU_OP_PAIR_DOUBLE, 64'h4010, 9'h0, 4'h3, LLPU_EXC_NONE);
		rd(`LLPU_OFF_LINK_LO, rv);
		check("link_lo", exp_link[31:0], rv);
		rd(`LLPU_OFF_LINK_HI, rv);
		check("link_hi", exp_link[63:32], rv);
		pulse_clear(1'b0);
		run(LLPU_OP_PAIR_WORD, 64'h5008, 9'h0, 4'h3, LLPU_EXC_NONE);
		pulse_clear(1'b1);
		rd(8'h20, rv);
		check("unmapped", 0, rv);
		complete_run();
	end

	initial begin
		#400000;
		miscompares++;
		complete_run();
	end
endmodule // llpu_unit_test
